// *** rtl/cobt_pkg.sv ***
// Constants for the CAN object interrupt and bit timing block.
// Assumes an 8-bit special function register space with byte offsets.
package cobt_pkg;

	// Register offsets in the SFR space
	localparam logic [7:0] OFS_BT_PRESCALE = 8'hb4;
	localparam logic [7:0] OFS_BT_JUMP_PROP = 8'hb5;
	localparam logic [7:0] OFS_STATUS_HIGH = 8'hba;
	localparam logic [7:0] OFS_STATUS_LOW = 8'hbb;
	localparam logic [7:0] OFS_IEN_HIGH = 8'hc2;
	localparam logic [7:0] OFS_IEN_LOW = 8'hc3;

	// Object counts
	localparam int NUM_OBJ = 15;
	localparam int LOW_OBJ = 8;
	localparam int HIGH_OBJ = 7;

	// Field positions and widths
	localparam int BRP_LSB = 1;
	localparam int BRP_W = 6;
	localparam int SJW_LSB = 5;
	localparam int SJW_W = 2;
	localparam int PRS_LSB = 1;
	localparam int PRS_W = 3;

	// Reset values
	localparam logic [7:0] IEN_LOW_RST = 8'h00;
	localparam logic [6:0] IEN_HIGH_RST = 7'h00;
	localparam logic [14:0] STATUS_RST = 15'h0000;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Phase segment lengths in quanta, fixed since they are not programmable here
	localparam logic [4:0] PHASE1_TQ = 5'h04;
	localparam logic [4:0] PHASE2_TQ = 5'h04;

	// Bit segments
	typedef enum logic [1:0] {
		COBT_SYNC,
		COBT_PROP,
		COBT_PH1,
		COBT_PH2
	} cobt_seg_t;

endpackage : cobt_pkg

// *** rtl/cobt_tq_if.sv ***
// Carrier between the bit timing logic and the quantum prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cobt_tq_if;
	logic [5:0] prescale;
	logic run;
	logic tick;

	// Prescaler end
	modport gen (
		input prescale,
		input run,
		output tick
	);

	// Bit timing end
	modport user (
		output prescale,
		output run,
		input tick
	);
endinterface : cobt_tq_if
`default_nettype wire

// *** rtl/cobt_prescaler.sv ***
// Time quantum prescaler: one tick every prescale+1 controller clocks.
// Assumes prescale is stable while run is high.
`timescale 1ns/1ns
`default_nettype none
module cobt_prescaler (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Quantum carrier
	cobt_tq_if.gen tq
);
	import cobt_pkg::*;

	logic [5:0] cnt_ff;
	logic tick_ff;
	wire logic at_end;
	wire logic [5:0] nxt_cnt;

	// Wrap at the programmed value so one quantum is prescale+1 clocks
	assign at_end = (cnt_ff == tq.prescale);
	assign nxt_cnt = (!tq.run || at_end) ? 6'h00 : cnt_ff + 6'h01; // R5
	assign tq.tick = tick_ff;

	// Counter held at zero while the controller is off
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			tick_ff <= tq.run && at_end; // R5
		end
	end

	// Clocks since the last tick, parked at the top while stopped: the first
	// quantum after a start has no earlier tick to measure from, so it is skipped
	logic [6:0] gap_ff;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_ff <= 7'h7f;
		end else if (ce_i && !tq.run) begin
			gap_ff <= 7'h7f;
		end else if (ce_i) begin
			gap_ff <= tick_ff ? 7'h00 : gap_ff + {6'h00, gap_ff != 7'h7f};
		end
	end

	tq_period_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R5
		ce_i && tick_ff && $past(tick_ff) == 1'b0 && tq.run && gap_ff != 7'h7f
		|-> gap_ff == {1'b0, tq.prescale})
		else $error("quantum period wrong");

endmodule : cobt_prescaler
`default_nettype wire

// *** rtl/cobt_top.sv ***
// CAN message object interrupt flags and enables plus bit timing set-up.
// Assumes a synchronous SFR port and a frame engine that pulses object events.
// Notes on behaviour
// R1 - Bits 7 to 0 of the low status register flag a pending interrupt of objects 0 to 7.
// R2 - The low status register is read-only, resets to zero and changes only by hardware.
// R3 - A writable enable register holds one enable per object 8 to 14 in bits 6 to 0, bit 7 spare.
// R4 - A writable enable register holds one enable per object 0 to 7, all clear at reset.
// R5 - The time quantum lasts prescaler field plus one controller clocks.
// R6 - On a relevant bus edge a bit is stretched or shortened by at most the jump width.
// R7 - The propagation segment lasts field plus one quanta.
// R8 - Software sizes the propagation segment for twice the network round trip delay.
// R9 - Software touches the bit timing registers only while the controller is off.
// R10 - The bit timing registers have no reset value and must be set before enabling.
// R11 - Reserved bits read as undefined and are never written with one.
// R12 - A second read-only status register flags objects 8 to 14 in bits 6 to 0, bit 7 spare.
// R13 - The object interrupt request is high while any enabled object has its flag set; the code registers it, one clock behind the flags and enables.
`timescale 1ns/1ns
`default_nettype none
module cobt_top (
	// Clock, reset, clock enable
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// SFR port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Controller state and frame engine events
	input wire logic controller_enable_i,
	input wire logic [cobt_pkg::NUM_OBJ-1:0] obj_event_i,
	input wire logic [cobt_pkg::NUM_OBJ-1:0] obj_clear_i,
	input wire logic bus_edge_i,
	// Results
	output logic obj_irq_o,
	output logic tq_tick_o,
	output logic bit_start_o,
	output logic sample_point_o
);
	import cobt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Smaller of two quanta counts
	function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
		min5 = (a < b) ? a : b;
	endfunction : min5

	// Field value plus one, widened to a quanta count
	function automatic logic [4:0] plus_one(input logic [2:0] f);
		plus_one = {2'b00, f} + 5'h01;
	endfunction : plus_one

	////////////////////////////////////////////////////////////////////////////
	// Register access decode

	logic [NUM_OBJ-1:0] flag_ff;
	logic [7:0] ien_low_ff;
	logic [6:0] ien_high_ff;
	logic [BRP_W-1:0] brp_ff;
	logic [SJW_W-1:0] sjw_ff;
	logic [PRS_W-1:0] prs_ff;
	logic [7:0] rdata_ff;
	logic irq_ff;

	wire logic wr_ien_low;
	wire logic wr_ien_high;
	wire logic wr_bt1;
	wire logic wr_bt2;
	wire logic bt_open;
	wire logic [7:0] rd_mux;
	wire logic [NUM_OBJ-1:0] nxt_flag;
	wire logic [NUM_OBJ-1:0] ien_all;

	// Timing writes are dropped while running, a change mid-frame would corrupt bits
	assign bt_open = !controller_enable_i; // R9
	assign wr_ien_low = sfr_wr_i && (sfr_addr_i == OFS_IEN_LOW);
	assign wr_ien_high = sfr_wr_i && (sfr_addr_i == OFS_IEN_HIGH);
	assign wr_bt1 = sfr_wr_i && bt_open && (sfr_addr_i == OFS_BT_PRESCALE); // R9
	assign wr_bt2 = sfr_wr_i && bt_open && (sfr_addr_i == OFS_BT_JUMP_PROP); // R9

	// Reserved bits read as zero, one of the values allowed for them
	assign rd_mux = (sfr_addr_i == OFS_STATUS_LOW) ? flag_ff[LOW_OBJ-1:0] : // R1
		(sfr_addr_i == OFS_STATUS_HIGH) ? {1'b0, flag_ff[NUM_OBJ-1:LOW_OBJ]} : // R12
		(sfr_addr_i == OFS_IEN_LOW) ? ien_low_ff :
		(sfr_addr_i == OFS_IEN_HIGH) ? {1'b0, ien_high_ff} : // R11
		(sfr_addr_i == OFS_BT_PRESCALE) ? {1'b0, brp_ff, 1'b0} :
		(sfr_addr_i == OFS_BT_JUMP_PROP) ? {1'b0, sjw_ff, 1'b0, prs_ff, 1'b0} :
		UNMAPPED_READ;

	// Set wins over clear so an event in the clear cycle is kept
	assign nxt_flag = (flag_ff & ~obj_clear_i) | obj_event_i; // R2
	assign ien_all = {ien_high_ff, ien_low_ff};

	////////////////////////////////////////////////////////////////////////////
	// Flags, enables, read data

	// Flags ignore SFR writes entirely
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_ff <= STATUS_RST; // R2
			ien_low_ff <= IEN_LOW_RST; // R4
			ien_high_ff <= IEN_HIGH_RST; // R3
			rdata_ff <= UNMAPPED_READ;
			irq_ff <= 1'b0;
		end else if (ce_i) begin
			flag_ff <= nxt_flag; // R1
			if (wr_ien_low) begin
				ien_low_ff <= sfr_wdata_i; // R4
			end
			if (wr_ien_high) begin
				ien_high_ff <= sfr_wdata_i[6:0]; // R3
			end
			if (sfr_rd_i) begin
				rdata_ff <= rd_mux;
			end
			irq_ff <= |(flag_ff & ien_all); // R13
		end
	end

	// Bit timing fields keep no reset value, software must load them first
	always_ff @(posedge clock_i) begin
		if (ce_i && wr_bt1) begin
			brp_ff <= sfr_wdata_i[BRP_LSB+BRP_W-1:BRP_LSB]; // R10
		end
		if (ce_i && wr_bt2) begin
			sjw_ff <= sfr_wdata_i[SJW_LSB+SJW_W-1:SJW_LSB]; // R10
			prs_ff <= sfr_wdata_i[PRS_LSB+PRS_W-1:PRS_LSB];
		end
	end

	assign sfr_rdata_o = rdata_ff;
	assign obj_irq_o = irq_ff;

	////////////////////////////////////////////////////////////////////////////
	// Quantum prescaler

	cobt_tq_if tq ();

	assign tq.prescale = brp_ff;
	assign tq.run = controller_enable_i;

	cobt_prescaler u_prescaler (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.tq(tq.gen)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bit segment sequencer

	cobt_seg_t seg_ff;
	cobt_seg_t nxt_seg;
	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic [4:0] ext_ff;
	logic [4:0] nxt_ext;
	logic [4:0] cut_ff;
	logic [4:0] nxt_cut;
	logic edge_ff;
	logic done_ff;
	logic nxt_done;
	logic tick_ff;
	logic start_ff;
	logic sample_ff;

	wire logic [4:0] prop_len;
	wire logic [4:0] sjw_len;
	wire logic [4:0] ph1_len;
	wire logic [4:0] ph2_len;
	wire logic [4:0] ph2_left;
	wire logic resync;

	assign prop_len = plus_one(prs_ff); // R7
	assign sjw_len = plus_one({1'b0, sjw_ff}); // R6
	assign ph1_len = PHASE1_TQ + ext_ff;
	assign ph2_len = PHASE2_TQ - cut_ff;
	assign ph2_left = PHASE2_TQ - cnt_ff;
	// Only one correction per bit; edges in the sync quantum need none
	assign resync = edge_ff && !done_ff && (seg_ff != COBT_SYNC);

	// Next segment, decided on each quantum
	always_comb begin
		nxt_seg = seg_ff;
		nxt_cnt = cnt_ff;
		nxt_ext = ext_ff;
		nxt_cut = cut_ff;
		nxt_done = done_ff || resync;
		case (seg_ff)
			COBT_SYNC: begin
				nxt_seg = COBT_PROP;
				nxt_cnt = 5'h00;
				nxt_ext = 5'h00;
				nxt_cut = 5'h00;
				nxt_done = 1'b0;
			end
			COBT_PROP: begin
				if (resync) begin
					nxt_ext = min5(cnt_ff + 5'h01, sjw_len); // R6
				end
				if (cnt_ff == prop_len - 5'h01) begin
					nxt_seg = COBT_PH1; // R7
					nxt_cnt = 5'h00;
				end else begin
					nxt_cnt = cnt_ff + 5'h01;
				end
			end
			COBT_PH1: begin
				if (resync) begin
					nxt_ext = min5(prop_len + cnt_ff + 5'h01, sjw_len); // R6
				end
				if (cnt_ff == ph1_len - 5'h01) begin
					nxt_seg = COBT_PH2;
					nxt_cnt = 5'h00;
				end else begin
					nxt_cnt = cnt_ff + 5'h01;
				end
			end
			COBT_PH2: begin
				if (resync && (ph2_left <= sjw_len)) begin
					nxt_seg = COBT_SYNC; // R6
				end else if (resync) begin
					nxt_cut = sjw_len; // R6
					nxt_cnt = cnt_ff + 5'h01;
				end else if (cnt_ff >= ph2_len - 5'h01) begin
					nxt_seg = COBT_SYNC;
				end else begin
					nxt_cnt = cnt_ff + 5'h01;
				end
			end
			default: begin
				nxt_seg = COBT_SYNC;
			end
		endcase
	end

	// Sequencer state, parked in sync while the controller is off
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seg_ff <= COBT_SYNC;
			cnt_ff <= 5'h00;
			ext_ff <= 5'h00;
			cut_ff <= 5'h00;
			edge_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce_i && !controller_enable_i) begin
			seg_ff <= COBT_SYNC;
			cnt_ff <= 5'h00;
			edge_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce_i && tq.tick) begin
			seg_ff <= nxt_seg;
			cnt_ff <= nxt_cnt;
			ext_ff <= nxt_ext;
			cut_ff <= nxt_cut;
			done_ff <= nxt_done;
			edge_ff <= bus_edge_i;
		end else if (ce_i && bus_edge_i) begin
			edge_ff <= 1'b1;
		end
	end

	// Timing pulses, one clock each
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_ff <= 1'b0;
			start_ff <= 1'b0;
			sample_ff <= 1'b0;
		end else if (ce_i) begin
			tick_ff <= tq.tick;
			start_ff <= tq.tick && controller_enable_i && (seg_ff != COBT_SYNC)
				&& (nxt_seg == COBT_SYNC);
			sample_ff <= tq.tick && controller_enable_i && (seg_ff == COBT_PH1)
				&& (nxt_seg == COBT_PH2);
		end
	end

	assign tq_tick_o = tick_ff;
	assign bit_start_o = start_ff;
	assign sample_point_o = sample_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence wr_low_s;
		ce_i && wr_ien_low;
	endsequence

	sequence wr_high_s;
		ce_i && wr_ien_high;
	endsequence

	sequence quiet_s;
		ce_i && !sfr_wr_i && obj_event_i == '0 && obj_clear_i == '0;
	endsequence

	flag_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
		ce_i && obj_event_i[0] |=> flag_ff[0])
		else $error("object flag not set by event");

	status_ro_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
		quiet_s |=> $stable(flag_ff))
		else $error("status flags changed without cause");

	ien_high_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
		wr_high_s |=> ien_high_ff == $past(sfr_wdata_i[6:0]))
		else $error("high enable not written");

	ien_low_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
		wr_low_s |=> ien_low_ff == $past(sfr_wdata_i))
		else $error("low enable not written");

	sjw_bound_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6
		controller_enable_i |-> ext_ff <= sjw_len && cut_ff <= sjw_len)
		else $error("resync exceeds jump width");

	prop_len_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
		ce_i && tq.tick && controller_enable_i && seg_ff == COBT_PROP
		&& nxt_seg == COBT_PH1 |-> cnt_ff == prs_ff)
		else $error("propagation segment length wrong");

	bt_lock_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R9
		ce_i && controller_enable_i |=> $stable(brp_ff) && $stable(prs_ff))
		else $error("bit timing changed while enabled");

	irq_out_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R13
		ce_i ##1 ce_i |-> obj_irq_o == |($past(flag_ff) & $past(ien_all)))
		else $error("interrupt request mismatch");

	high_status_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R12
		ce_i && sfr_rd_i && sfr_addr_i == OFS_STATUS_HIGH
		|=> sfr_rdata_o == {1'b0, $past(flag_ff[NUM_OBJ-1:LOW_OBJ])})
		else $error("high status read wrong");

endmodule : cobt_top
`default_nettype wire

// *** bench/cobt_can_node.sv ***
// Far-side CAN node model: makes the recessive-to-dominant edges the block sees.
// Assumes one clock shared with the block; each edge is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module cobt_can_node (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Edge seen on the bus
	output logic bus_edge_o
);
	import cobt_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Quiet line at start, so no edge is seen before a frame
	initial bus_edge_o = 1'b0;

	// Edge after a chosen number of clocks; the pulse drops again at once
	task automatic fire(input int d);
		repeat (d) @(posedge clock_i);
		bus_edge_o <= rstn_i;
		@(posedge clock_i);
		bus_edge_o <= 1'b0;
	endtask : fire
endmodule : cobt_can_node
`default_nettype wire

// *** bench/cobt_top_bench.sv ***
// Self-checking bench for the object interrupt and bit timing block.
// Assumes single-cycle SFR strobes; ce_i drops only in the freeze test.
`timescale 1ns/1ns
`default_nettype none
module cobt_top_bench;
	import cobt_pkg::*;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic enable = 1'b0;
	logic ce = 1'b1;
	logic [14:0] ev = 15'h0000;
	logic [14:0] clr = 15'h0000;
	logic [7:0] rdata;
	logic irq, tick, bit_start, sample;
	wire logic bus_edge;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and cycle count
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;

	// Block and far-side node
	cobt_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
		.controller_enable_i(enable), .obj_event_i(ev), .obj_clear_i(clr),
		.bus_edge_i(bus_edge), .obj_irq_o(irq), .tq_tick_o(tick),
		.bit_start_o(bit_start), .sample_point_o(sample));
	cobt_can_node node (.clock_i(clock_i), .rstn_i(rstn_i), .bus_edge_o(bus_edge));

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : chk

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask : sfr_wr

	// Read data lands on the same clock edge that takes the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 chk(rdata, exp, msg);
	endtask : rd_chk

	task automatic pulse_ev(input logic [14:0] s, input logic [14:0] c);
		@(posedge clock_i);
		ev <= s;
		clr <= c;
		@(posedge clock_i);
		ev <= 15'h0000;
		clr <= 15'h0000;
	endtask : pulse_ev

	function automatic logic pick(input int w);
		return (w == 0) ? tick : ((w == 1) ? bit_start : sample);
	endfunction : pick

	// Bounded wait for a pulse, returns the cycle it was seen in
	task automatic wait_for(input int w, output int at);
		int i;
		i = 0;
		do begin
			@(posedge clock_i);
			#1;
			i++;
		end while (pick(w) !== 1'b1 && i < 200);
		if (pick(w) !== 1'b1) chk(8'h01, 8'h00, "pulse missing");
		at = cyc;
	endtask : wait_for

	// Spacing of two pulses, with an optional bus edge d clocks after the first
	task automatic gap(input int w, input int d, input int exp, input string msg);
		int a, b;
		wait_for(w, a);
		if (d >= 0) node.fire(d);
		wait_for(w, b);
		chk(8'(b - a), 8'(exp), msg);
	endtask : gap

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rd_chk(OFS_STATUS_LOW, 8'h00, "status low reset");
		rd_chk(OFS_STATUS_HIGH, 8'h00, "status high reset");
		rd_chk(OFS_IEN_HIGH, 8'h00, "enable high reset");
		rd_chk(OFS_IEN_LOW, 8'h00, "enable low reset");
		rd_chk(8'h40, 8'h00, "unmapped read");
		$display("test reset done");
	endtask : t_reset

	task automatic t_enables();
		sfr_wr(OFS_IEN_HIGH, 8'h7f);
		rd_chk(OFS_IEN_HIGH, 8'h7f, "enable high readback");
		sfr_wr(OFS_IEN_LOW, 8'ha5);
		rd_chk(OFS_IEN_LOW, 8'ha5, "enable low readback");
		sfr_wr(OFS_IEN_LOW, 8'h00);
		sfr_wr(OFS_IEN_HIGH, 8'h00);
		$display("test enables done");
	endtask : t_enables

	task automatic t_status();
		sfr_wr(OFS_STATUS_LOW, 8'hff);
		rd_chk(OFS_STATUS_LOW, 8'h00, "status low written");
		pulse_ev(15'h0208, 15'h0000);
		rd_chk(OFS_STATUS_LOW, 8'h08, "flag 3 set");
		rd_chk(OFS_STATUS_HIGH, 8'h02, "flag 9 set");
		pulse_ev(15'h0008, 15'h0208);
		rd_chk(OFS_STATUS_LOW, 8'h08, "set beats clear");
		rd_chk(OFS_STATUS_HIGH, 8'h00, "flag 9 cleared");
		$display("test status done");
	endtask : t_status

	// Clock enable low must hold every flag; flag 3 stays pending afterwards
	task automatic t_freeze();
		@(posedge clock_i);
		ce <= 1'b0;
		pulse_ev(15'h0001, 15'h0008);
		@(posedge clock_i);
		ce <= 1'b1;
		rd_chk(OFS_STATUS_LOW, 8'h08, "flags frozen");
		pulse_ev(15'h0001, 15'h0001);
		rd_chk(OFS_STATUS_LOW, 8'h09, "flag 0 set beats clear");
		pulse_ev(15'h0000, 15'h0001);
		rd_chk(OFS_STATUS_LOW, 8'h08, "flag 0 cleared");
		$display("test freeze done");
	endtask : t_freeze

	// Flag 3 pending here, all enables off
	task automatic t_irq();
		#1 chk({7'h00, irq}, 8'h00, "irq while masked");
		sfr_wr(OFS_IEN_LOW, 8'h08);
		@(posedge clock_i);
		#1 chk({7'h00, irq}, 8'h01, "irq on enable");
		pulse_ev(15'h0000, 15'h0008);
		#1 chk({7'h00, irq}, 8'h01, "irq lags clear");
		@(posedge clock_i);
		#1 chk({7'h00, irq}, 8'h00, "irq after clear");
		pulse_ev(15'h1000, 15'h0000);
		#1 chk({7'h00, irq}, 8'h00, "irq lags event");
		@(posedge clock_i);
		#1 chk({7'h00, irq}, 8'h00, "object 12 masked");
		sfr_wr(OFS_IEN_HIGH, 8'h10);
		@(posedge clock_i);
		#1 chk({7'h00, irq}, 8'h01, "object 12 irq");
		$display("test irq done");
	endtask : t_irq

	// Quantum 3 clocks, prop 2 quanta, jump 1 quantum: bit 11 quanta, 33 clocks
	task automatic t_timing();
		sfr_wr(OFS_BT_PRESCALE, 8'h04);
		sfr_wr(OFS_BT_JUMP_PROP, 8'h02);
		rd_chk(OFS_BT_PRESCALE, 8'h04, "prescale readback");
		rd_chk(OFS_BT_JUMP_PROP, 8'h02, "jump prop readback");
		@(posedge clock_i);
		enable <= 1'b1;
		gap(0, -1, 3, "quantum length");
		gap(1, -1, 33, "bit length");
		gap(2, -1, 33, "sample spacing");
		gap(1, 12, 36, "late edge stretch");
		gap(1, 24, 30, "early edge cut");
		sfr_wr(OFS_BT_PRESCALE, 8'h08);
		rd_chk(OFS_BT_PRESCALE, 8'h04, "write while enabled");
		@(posedge clock_i);
		enable <= 1'b0;
		@(posedge clock_i);
		repeat (40) begin
			@(posedge clock_i);
			#1 chk({7'h00, bit_start}, 8'h00, "bit start while off");
		end
		$display("test timing done");
	endtask : t_timing

	// Jump width 2 quanta: a late edge stretches by 2, an edge near the end closes the bit
	task automatic t_jump();
		sfr_wr(OFS_BT_JUMP_PROP, 8'h22);
		rd_chk(OFS_BT_JUMP_PROP, 8'h22, "jump width readback");
		@(posedge clock_i);
		enable <= 1'b1;
		gap(1, 12, 39, "late edge capped stretch");
		gap(1, 27, 30, "early edge resync");
		$display("test jump done");
	endtask : t_jump

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		t_reset();
		t_enables();
		t_status();
		t_freeze();
		t_irq();
		t_timing();
		t_jump();
		give_verdict();
	end

	// Tests take well under 3000 cycles
	initial begin
		#100000;
		error_cnt++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : cobt_top_bench
`default_nettype wire
